// [sww_pkg.sv]
/*
  Shared constants and types for the subtract-from-W execution block.
  Assumes an 8-bit data path, a 12-bit data-memory space and APB at 32 bits.
*/
package sww_pkg;

  // Data and address widths
  localparam int SWW_DW = 8;
  localparam int SWW_AW = 12;
  localparam int SWW_BW = 4;

  // Opcode fields
  localparam logic [7:0] SWW_OPC_LIT = 8'h08;
  localparam logic [5:0] SWW_OPC_FILE = 6'h17;
  localparam int SWW_D_BIT = 9;
  localparam int SWW_A_BIT = 8;

  // Access bank split and indexed window
  localparam logic [7:0] SWW_IDX_MAX = 8'h5F;
  localparam logic [7:0] SWW_ACC_SPLIT = 8'h60;
  localparam logic [3:0] SWW_ACC_HI_BANK = 4'hF;

  // Flag positions in the status word
  localparam int SWW_F_C = 0;
  localparam int SWW_F_DC = 1;
  localparam int SWW_F_Z = 2;
  localparam int SWW_F_OV = 3;
  localparam int SWW_F_N = 4;
  localparam int SWW_FW = 5;

  // Register byte offsets
  localparam logic [11:0] SWW_OFS_WREG = 12'h000;
  localparam logic [11:0] SWW_OFS_STATUS = 12'h004;
  localparam logic [11:0] SWW_OFS_BANK = 12'h008;
  localparam logic [11:0] SWW_OFS_CTRL = 12'h00C;
  localparam logic [11:0] SWW_OFS_IDX = 12'h010;
  localparam logic [11:0] SWW_OFS_INFO = 12'h014;

  // Reset values
  localparam logic [7:0] SWW_WREG_RST = 8'h00;
  localparam logic [4:0] SWW_STATUS_RST = 5'h00;
  localparam logic [3:0] SWW_BANK_RST = 4'h0;
  localparam logic SWW_EXT_RST = 1'b0;
  localparam logic [11:0] SWW_IDX_RST = 12'h000;

  // Instruction phases
  typedef enum logic [2:0] {SWW_IDLE, SWW_Q1, SWW_Q2, SWW_Q3, SWW_Q4} sww_phase_t;

  // Whole state of the top module
  typedef struct packed {
    sww_phase_t phase;
    logic [15:0] instr;
    logic is_lit;
    logic is_file;
    logic illegal;
    logic last_illegal;
    logic indexed;
    logic [11:0] addr;
    logic [7:0] opnd;
    logic [7:0] res;
    logic [4:0] flags;
    logic [4:0] status;
    logic [7:0] wreg;
    logic [3:0] bank;
    logic ext_en;
    logic [11:0] idx_base;
    logic dmem_re;
    logic dmem_we;
    logic [7:0] dmem_wdata;
    logic done;
    logic ready;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sww_state_t;

endpackage

// [sww_alu.sv]
/*
  Eight-bit subtractor giving the difference and the five arithmetic flags.
  Pure logic; the caller registers both outputs.
*/
`timescale 1ns/1ps
module sww_alu
  import sww_pkg::*;
#(
  parameter int DW = SWW_DW
)
(
  input wire logic [DW-1:0] minuend_i,
  input wire logic [DW-1:0] subtrahend_i,
  output logic [DW-1:0] diff_o,
  output logic [SWW_FW-1:0] flags_o
);

  // Full and low-nibble sums of minuend plus inverted subtrahend plus one
  logic [DW:0] full_sum;
  logic [4:0] nib_sum;

  // Two's complement subtraction with carry meaning no borrow
  always_comb
  begin
    full_sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + {{DW{1'b0}}, 1'b1};
    nib_sum = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + 5'h01;
    diff_o = full_sum[DW-1:0];
    flags_o = '0;
    flags_o[SWW_F_C] = full_sum[DW];
    flags_o[SWW_F_DC] = nib_sum[4];
    flags_o[SWW_F_Z] = (full_sum[DW-1:0] == '0);
    flags_o[SWW_F_N] = full_sum[DW-1];
    // Signed wrap when operand signs differ and result sign leaves minuend's
    flags_o[SWW_F_OV] = (minuend_i[DW-1] ^ subtrahend_i[DW-1])
                      & (full_sum[DW-1] ^ minuend_i[DW-1]);
  end

endmodule // sww_alu

// [sww_addr.sv]
/*
  File-register address former: access bank, selected bank or indexed mode.
  Pure logic; the index base is supplied from a register in the caller.
*/
`timescale 1ns/1ps
module sww_addr
  import sww_pkg::*;
(
  input wire logic [7:0] f_i,
  input wire logic access_bit_i,
  input wire logic ext_en_i,
  input wire logic [SWW_BW-1:0] bank_i,
  input wire logic [SWW_AW-1:0] idx_base_i,
  output logic [SWW_AW-1:0] addr_o,
  output logic indexed_o
);

  // Pick one of three address forms
  always_comb
  begin
    indexed_o = !access_bit_i && ext_en_i && (f_i <= SWW_IDX_MAX);
    if (indexed_o)
    begin
      addr_o = idx_base_i + {4'h0, f_i};
    end
    else if (access_bit_i)
    begin
      addr_o = {bank_i, f_i};
    end
    else if (f_i < SWW_ACC_SPLIT)
    begin
      addr_o = {4'h0, f_i};
    end
    else
    begin
      addr_o = {SWW_ACC_HI_BANK, f_i};
    end
  end

endmodule // sww_addr

// [sww_top.sv]
/*
  Execution block for the two subtract-from-W instructions, with its APB
  register file (W, status flags, bank selector, control, index base, info).
  Assumes decode logic on the same clock hands over one 16-bit opcode with a
  valid strobe, and a data memory that answers a read in the same cycle.
  Each opcode runs four phases after it is taken and ends with a one-cycle
  done pulse; a new opcode is taken only while ready is shown.
  Register accesses always answer with one wait state; a core write of W or
  the flags wins over a bus write landing at the same edge.
  The clock enable freezes every register, the bus answer included.
*/
// Our own choices: the placing of the registers and the APB register port.
// Notes on behaviour
// - Literal op writes literal minus W to W
// - Literal op: decode, read literal, process, write W
// - File op computes file minus W, eight bits
// - Destination bit: clear to W, set to file
// - Access bit clear: access bank; set: bank selector
// - Indexed mode when ext set, access clear, f<=95
// - File op: decode, read file, process, write dest
// - No borrow sets carry; a nonzero difference clears zero; negative is bit 7 of the difference
// - Zero difference sets zero and carry, clears negative
// - Borrow wraps result, clears carry; negative is bit 7 of the result
`timescale 1ns/1ps
module sww_top
  import sww_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Instruction hand-over from decode
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  output logic instr_ready_o,
  output logic done_o,
  output logic illegal_o,
  // Data memory port
  output logic [sww_pkg::SWW_AW-1:0] dmem_addr_o,
  output logic dmem_re_o,
  input wire logic [sww_pkg::SWW_DW-1:0] dmem_rdata_i,
  output logic dmem_we_o,
  output logic [sww_pkg::SWW_DW-1:0] dmem_wdata_o,
  // Core state seen by the rest of the core
  output logic [sww_pkg::SWW_DW-1:0] wreg_o,
  output logic [sww_pkg::SWW_FW-1:0] status_o,
  // APB slave
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  import sww_pkg::*;

  // Registered state and its next value
  sww_state_t st_ff;
  sww_state_t nxt_st;

  // Subtractor results
  logic [SWW_DW-1:0] alu_diff;
  logic [SWW_FW-1:0] alu_flags;

  // Address former results
  logic [SWW_AW-1:0] form_addr;
  logic form_indexed;

  // APB phase qualifiers
  logic apb_first;
  logic apb_done;

  // Known register offset check
  function automatic logic reg_hit(input logic [11:0] a);
    begin
      reg_hit = (a == SWW_OFS_WREG) || (a == SWW_OFS_STATUS)
             || (a == SWW_OFS_BANK) || (a == SWW_OFS_CTRL)
             || (a == SWW_OFS_IDX) || (a == SWW_OFS_INFO);
    end
  endfunction

  // Literal subtract opcode match
  function automatic logic op_is_lit(input logic [15:0] op);
    begin
      op_is_lit = (op[15:8] == SWW_OPC_LIT);
    end
  endfunction

  // File subtract opcode match
  function automatic logic op_is_file(input logic [15:0] op);
    begin
      op_is_file = (op[15:10] == SWW_OPC_FILE);
    end
  endfunction

  // Read value of a register, zero padded
  function automatic logic [31:0] reg_read(input logic [11:0] a,
                                           input sww_state_t s);
    begin
      reg_read = 32'h0000_0000;
      case (a)
        // Working register, low byte
        SWW_OFS_WREG:
        begin
          reg_read[7:0] = s.wreg;
        end
        // Arithmetic flags
        SWW_OFS_STATUS:
        begin
          reg_read[SWW_FW-1:0] = s.status;
        end
        // Bank selector
        SWW_OFS_BANK:
        begin
          reg_read[SWW_BW-1:0] = s.bank;
        end
        // Extended set enable
        SWW_OFS_CTRL:
        begin
          reg_read[0] = s.ext_en;
        end
        // Index base for indexed mode
        SWW_OFS_IDX:
        begin
          reg_read[SWW_AW-1:0] = s.idx_base;
        end
        // Busy, last illegal, last indexed
        SWW_OFS_INFO:
        begin
          reg_read[0] = (s.phase != SWW_IDLE);
          reg_read[1] = s.last_illegal;
          reg_read[2] = s.indexed;
        end
        // Unmapped reads zero
        default:
        begin
          reg_read = 32'h0000_0000;
        end
      endcase
    end
  endfunction

  // Difference of latched operand and W
  sww_alu u_alu (
    .minuend_i(st_ff.opnd),
    .subtrahend_i(st_ff.wreg),
    .diff_o(alu_diff),
    .flags_o(alu_flags)
  );

  // Address of the file operand from latched opcode
  sww_addr u_addr (
    .f_i(st_ff.instr[7:0]),
    .access_bit_i(st_ff.instr[SWW_A_BIT]),
    .ext_en_i(st_ff.ext_en),
    .bank_i(st_ff.bank),
    .idx_base_i(st_ff.idx_base),
    .addr_o(form_addr),
    .indexed_o(form_indexed)
  );

  // First access cycle answers next edge; second cycle completes
  assign apb_first = psel_i && penable_i && !st_ff.pready;
  assign apb_done = psel_i && penable_i && st_ff.pready;

  // Next-state logic for bus, registers and the four phases
  always_comb
  begin
    nxt_st = st_ff;
    // One-cycle pulses default low
    nxt_st.done = 1'b0;
    nxt_st.dmem_we = 1'b0;
    nxt_st.pready = 1'b0;

    // APB answer, one wait state
    if (apb_first)
    begin
      // Answer shows during the second access cycle
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = !reg_hit(paddr_i);
      nxt_st.prdata = pwrite_i ? 32'h0000_0000 : reg_read(paddr_i, st_ff);
    end
    else if (!psel_i)
    begin
      // Bus idle: drop the old answer
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata = 32'h0000_0000;
    end

    // APB write lands at the completing edge
    if (apb_done && pwrite_i)
    begin
      case (paddr_i)
        // Working register
        SWW_OFS_WREG:
        begin
          nxt_st.wreg = pwdata_i[7:0];
        end
        // Flags, software may preset them
        SWW_OFS_STATUS:
        begin
          nxt_st.status = pwdata_i[SWW_FW-1:0];
        end
        // Bank used when the access bit is set
        SWW_OFS_BANK:
        begin
          nxt_st.bank = pwdata_i[SWW_BW-1:0];
        end
        // Extended set enable
        SWW_OFS_CTRL:
        begin
          nxt_st.ext_en = pwdata_i[0];
        end
        // Index base
        SWW_OFS_IDX:
        begin
          nxt_st.idx_base = pwdata_i[SWW_AW-1:0];
        end
        default:
        begin
          // Info and unmapped: write ignored
          nxt_st.wreg = nxt_st.wreg;
        end
      endcase
    end

    // Instruction sequencer; core updates override bus writes
    case (st_ff.phase)
      SWW_IDLE:
      begin
        // Take a new opcode only while ready is shown
        if (instr_valid_i && st_ff.ready)
        begin
          nxt_st.instr = instr_i;
          nxt_st.phase = SWW_Q1;
        end
      end
      SWW_Q1:
      begin
        // Decode and form the operand address
        nxt_st.is_lit = op_is_lit(st_ff.instr);
        nxt_st.is_file = op_is_file(st_ff.instr);
        // Neither subtract form: run the phases, write nothing
        nxt_st.illegal = !(op_is_lit(st_ff.instr) || op_is_file(st_ff.instr));
        nxt_st.addr = form_addr;
        nxt_st.indexed = form_indexed;
        // Only the file form touches data memory
        nxt_st.dmem_re = op_is_file(st_ff.instr);
        nxt_st.phase = SWW_Q2;
      end
      SWW_Q2:
      begin
        // Read the literal or the file register
        if (st_ff.is_lit)
        begin
          // Literal straight from the opcode
          nxt_st.opnd = st_ff.instr[7:0];
        end
        else
        begin
          // File byte read during this phase
          nxt_st.opnd = dmem_rdata_i;
        end
        nxt_st.dmem_re = 1'b0;
        nxt_st.phase = SWW_Q3;
      end
      SWW_Q3:
      begin
        // Process: operand minus W and flags
        nxt_st.res = alu_diff;
        nxt_st.flags = alu_flags;
        nxt_st.phase = SWW_Q4;
      end
      SWW_Q4:
      begin
        // Write the destination and the flags
        // Illegal opcode leaves W, memory and flags alone
        if (!st_ff.illegal)
        begin
          if (st_ff.is_file && st_ff.instr[SWW_D_BIT])
          begin
            // Destination bit set: back to the file register
            nxt_st.dmem_we = 1'b1;
            nxt_st.dmem_wdata = st_ff.res;
          end
          else
          begin
            // Literal form, or destination bit clear: to W
            nxt_st.wreg = st_ff.res;
          end
          nxt_st.status = st_ff.flags;
        end
        nxt_st.last_illegal = st_ff.illegal;
        nxt_st.done = 1'b1;
        nxt_st.phase = SWW_IDLE;
      end
      default:
      begin
        // Stray code: back to idle
        nxt_st.phase = SWW_IDLE;
      end
    endcase

    // Ready whenever the next phase is idle
    nxt_st.ready = (nxt_st.phase == SWW_IDLE);
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      // Clear all, then the register reset values
      st_ff <= '0;
      st_ff.wreg <= SWW_WREG_RST;
      st_ff.status <= SWW_STATUS_RST;
      st_ff.bank <= SWW_BANK_RST;
      st_ff.ext_en <= SWW_EXT_RST;
      st_ff.idx_base <= SWW_IDX_RST;
    end
    else if (ce_i)
    begin
      // Enable low freezes every register
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  // Instruction hand-over
  assign instr_ready_o = st_ff.ready;
  assign done_o = st_ff.done;
  assign illegal_o = st_ff.last_illegal;

  // Data memory strobes, address and write byte
  assign dmem_addr_o = st_ff.addr;
  assign dmem_re_o = st_ff.dmem_re;
  assign dmem_we_o = st_ff.dmem_we;
  assign dmem_wdata_o = st_ff.dmem_wdata;

  // Core state
  assign wreg_o = st_ff.wreg;
  assign status_o = st_ff.status;

  // Bus answer
  assign prdata_o = st_ff.prdata;
  assign pready_o = st_ff.pready;
  assign pslverr_o = st_ff.pslverr;

endmodule // sww_top

// [sww_monitor.sv]
/*
  Port checker for the subtract block: instruction timing, memory strobes,
  flag relations and the APB wait state.
  Assumes the clock enable is held high while it watches.
*/
`timescale 1ns/1ps
module sww_monitor
  import sww_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_ready_o,
  input wire logic done_o,
  input wire logic illegal_o,
  input wire logic dmem_re_o,
  input wire logic dmem_we_o,
  input wire logic [7:0] dmem_wdata_o,
  input wire logic [7:0] wreg_o,
  input wire logic [4:0] status_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Opcode taken, its kind, and the result wherever it went
  logic tk;
  logic fop;
  logic lop;
  logic [7:0] res;
  assign tk = instr_valid_i && instr_ready_o;
  assign fop = instr_i[15:10] == SWW_OPC_FILE;
  assign lop = instr_i[15:8] == SWW_OPC_LIT;
  assign res = dmem_we_o ? dmem_wdata_o : wreg_o;
  property p_done; tk |-> ##5 done_o; endproperty
  a_done: assert property (p_done) else $error("done late");
  property p_busy; tk |=> !instr_ready_o [*4] ##1 instr_ready_o; endproperty
  a_busy: assert property (p_busy) else $error("ready wrong");
  property p_rd; tk && fop |-> ##2 dmem_re_o; endproperty
  a_rd: assert property (p_rd) else $error("no file read");
  property p_lit; tk && lop |-> ##2 !dmem_re_o ##3 !dmem_we_o; endproperty
  a_lit: assert property (p_lit) else $error("literal used memory");
  property p_wf; tk && fop && instr_i[SWW_D_BIT] |-> ##5 dmem_we_o && done_o; endproperty
  a_wf: assert property (p_wf) else $error("file not written");
  property p_ww; tk && fop && !instr_i[SWW_D_BIT] |-> ##5 !dmem_we_o; endproperty
  a_ww: assert property (p_ww) else $error("file written");
  property p_z; done_o && !illegal_o |-> status_o[SWW_F_Z] == (res == 8'h00); endproperty
  a_z: assert property (p_z) else $error("zero flag");
  property p_n; done_o && !illegal_o |-> status_o[SWW_F_N] == res[7]; endproperty
  a_n: assert property (p_n) else $error("negative flag");
  property p_zc; done_o && !illegal_o && status_o[SWW_F_Z] |-> status_o[SWW_F_C]; endproperty
  a_zc: assert property (p_zc) else $error("zero without carry");
  property p_apb; psel_i && $rose(penable_i) |=> pready_o; endproperty
  a_apb: assert property (p_apb) else $error("apb wait");
  c_lit: cover property (tk && lop);
  c_we: cover property (dmem_we_o);
  c_brw: cover property (done_o && !status_o[SWW_F_C]);
endmodule // sww_monitor
bind sww_top sww_monitor sww_monitor_i (.clk_i, .rst_n_i, .instr_valid_i, .instr_i,
  .instr_ready_o, .done_o, .illegal_o, .dmem_re_o, .dmem_we_o, .dmem_wdata_o, .wreg_o,
  .status_o, .psel_i, .penable_i, .pready_o);

// [sww_dmem.sv]
/*
  Data memory model: combinational read, write on the clock edge.
  Assumes the block drives address and strobes from its own registers.
*/
`timescale 1ns/1ps
module sww_dmem
  import sww_pkg::*;
(
  input wire logic clk_i,
  input wire logic [SWW_AW-1:0] addr_i,
  input wire logic re_i,
  input wire logic we_i,
  input wire logic [SWW_DW-1:0] wdata_i,
  output logic [SWW_DW-1:0] rdata_o
);
  logic [SWW_DW-1:0] mem [0:4095]; // Byte store
  logic [SWW_DW-1:0] last_ff; // Last byte driven
  // Known pattern so a wrong address shows
  initial
  begin
    last_ff = 8'h00;
    for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
  end
  // Released bus shows the inverse of its last value
  assign rdata_o = re_i ? mem[addr_i] : ~last_ff;
  always @(posedge clk_i)
  begin
    if (re_i) last_ff <= mem[addr_i];
    if (we_i) mem[addr_i] <= wdata_i;
  end
endmodule // sww_dmem

// [test_subtract_w_instructions.sv]
/*
  Testbench for the subtract block: APB set-up, literal and file operations.
  Assumes the data memory model and the bound checker.
*/
`timescale 1ns/1ps
module test_subtract_w_instructions;
  import sww_pkg::*;
  logic clk_i = 0, rst_n_i = 0, ce_i = 1, instr_valid_i = 0;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0, er;
  logic [15:0] instr_i = 16'h0000;
  logic [11:0] paddr_i = 12'h000, dmem_addr_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic instr_ready_o, done_o, illegal_o, dmem_re_o, dmem_we_o, pready_o, pslverr_o;
  logic [7:0] dmem_rdata_i, dmem_wdata_o, wreg_o;
  logic [4:0] status_o;
  int err_count = 0, cmp_count = 0, cyc = 0;
  logic [7:0] lk [5] = '{8'h02, 8'h02, 8'h02, 8'h80, 8'h7F}; // Literals
  logic [7:0] lw [5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h80}; // W values
  sww_top sww_top_i (.clk_i, .rst_n_i, .ce_i, .instr_valid_i, .instr_i, .instr_ready_o,
    .done_o, .illegal_o, .dmem_addr_o, .dmem_re_o, .dmem_rdata_i, .dmem_we_o, .dmem_wdata_o,
    .wreg_o, .status_o, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o);
  sww_dmem sww_dmem_i (.clk_i, .addr_i(dmem_addr_o), .re_i(dmem_re_o), .we_i(dmem_we_o),
    .wdata_i(dmem_wdata_o), .rdata_o(dmem_rdata_i));
  initial forever #10 clk_i = ~clk_i;
  // Hang guard
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Hand one opcode over and wait for its end
  task automatic exec(input logic [15:0] op);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= op;
    do @(posedge clk_i); while (instr_ready_o !== 1'b1);
    instr_valid_i <= 1'b0;
    do @(posedge clk_i); while (done_o !== 1'b1);
  endtask
  // Load W and memory, run, compare result, flags and the memory write strobe
  task automatic sub(input logic [15:0] op, input logic [11:0] ad, input logic [7:0] m, w);
    logic [7:0] df;
    logic fo;
    logic dw;
    logic [4:0] fl;
    fo = op[15:10] == SWW_OPC_FILE;
    dw = fo && op[SWW_D_BIT];
    df = m - w;
    apb(1'b1, SWW_OFS_WREG, {24'h0, w});
    if (fo) sww_dmem_i.mem[ad] = m;
    exec(op);
    // Expected N, OV, Z, DC, C from the operands alone
    fl = {df[7], m[7] != w[7] && df[7] != m[7], df == 0, m[3:0] >= w[3:0], m >= w};
    chk("status", fl, status_o);
    chk("wreg", dw ? w : df, wreg_o);
    chk("we", dw, dmem_we_o);
    if (fo) chk("addr", ad, dmem_addr_o);
    if (dw) chk("wdata", df, dmem_wdata_o);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, SWW_OFS_STATUS, 32'h0);
    chk("status rst", SWW_STATUS_RST, rd);
    apb(1'b0, SWW_OFS_IDX, 32'h0);
    chk("idx rst", SWW_IDX_RST, rd);
    apb(1'b0, 12'h018, 32'h0);
    chk("slverr", 1'h1, er);
    apb(1'b1, SWW_OFS_BANK, 32'hFFFF_FFFF);
    apb(1'b0, SWW_OFS_BANK, 32'h0);
    chk("bank", 32'hF, rd);
    for (int i = 0; i < 5; i++) sub({SWW_OPC_LIT, lk[i]}, 12'h000, lk[i], lw[i]);
    apb(1'b1, SWW_OFS_BANK, 32'h3);
    sub({SWW_OPC_FILE, 2'h1, 8'h45}, 12'h345, 8'h03, 8'h02);
    sub({SWW_OPC_FILE, 2'h2, 8'h70}, 12'hF70, 8'h01, 8'h02);
    sub({SWW_OPC_FILE, 2'h0, 8'h10}, 12'h010, 8'h05, 8'h05);
    apb(1'b1, SWW_OFS_CTRL, 32'h1);
    apb(1'b1, SWW_OFS_IDX, 32'h200);
    sub({SWW_OPC_FILE, 2'h2, 8'h5F}, 12'h25F, 8'h09, 8'h04);
    sub({SWW_OPC_FILE, 2'h0, 8'h60}, 12'hF60, 8'h90, 8'h14);
    sub({SWW_OPC_FILE, 2'h1, 8'h10}, 12'h310, 8'h20, 8'h07);
    apb(1'b1, SWW_OFS_WREG, 32'h33);
    exec(16'hFFFF);
    chk("illegal", 1'h1, illegal_o);
    chk("w kept", 8'h33, wreg_o);
    // Info: idle, last opcode illegal, not indexed
    apb(1'b0, SWW_OFS_INFO, 32'h0);
    chk("info", 32'h2, rd);
    final_report();
  end
endmodule // test_subtract_w_instructions
